// >>> inc/vdl_pkg.sv
// constants for the vlan lookup and indirect table access block
// assumes one switch core clock and a lookup engine outside the block
//
// What this block does
// - control value 0x1800 reads dynamic entry zero
// - top word bit 71 high means reread
// - then words give bits 63:48,47:32,31:16,15:0
// - vlan table used only when mode bit set
// - sixteen 20-bit entries, bit 19 valid
// - bits 18:16 member ports, forward on misses
// - bits 15:12 filter identifier keys address lookups
// - bits 11:0 vlan identifier, default 0x001
// - untagged or null tag takes port default
// - non-null tag identifier used for lookup
// - missing or invalid entry drops, no learning
// - destination miss floods members except ingress
// - source miss learns filter identifier and source
// - vlan read 0x1402 fills words five, four
// - vlan write loads words five, four first
// - dynamic bits 65:56 hold valid entry count
package vdl_pkg;

  // =====================================================================
  // register offsets (word index on the register port)
  localparam logic [3:0] VDL_ADR_IAC   = 4'h0;
  localparam logic [3:0] VDL_ADR_DW1   = 4'h1;
  localparam logic [3:0] VDL_ADR_DW2   = 4'h2;
  localparam logic [3:0] VDL_ADR_DW3   = 4'h3;
  localparam logic [3:0] VDL_ADR_DW4   = 4'h4;
  localparam logic [3:0] VDL_ADR_DW5   = 4'h5;
  localparam logic [3:0] VDL_ADR_GC2   = 4'h6;
  localparam logic [3:0] VDL_ADR_PVID  = 4'h7;

  // =====================================================================
  // control value fields
  localparam int         VDL_IAC_RD    = 12;
  localparam int         VDL_IAC_SELH  = 11;
  localparam int         VDL_IAC_SELL  = 10;
  localparam logic [1:0] VDL_SEL_VLAN  = 2'h1;
  localparam logic [1:0] VDL_SEL_DYN   = 2'h2;
  localparam int         VDL_GC2_VLAN  = 15;

  // =====================================================================
  // vlan entry layout and defaults
  localparam int          VDL_ENTRIES  = 16;
  localparam int          VDL_E_VALID  = 19;
  localparam int          VDL_E_MEMH   = 18;
  localparam int          VDL_E_MEML   = 16;
  localparam int          VDL_E_FIDH   = 15;
  localparam int          VDL_E_FIDL   = 12;
  localparam int          VDL_E_VIDH   = 11;
  localparam logic [19:0] VDL_ENTRY_RST = 20'hF_0001;
  localparam logic [11:0] VDL_PVID_RST = 12'h001;
  localparam logic [11:0] VDL_VID_NULL = 12'h000;
  localparam logic [2:0]  VDL_ALL_PORTS = 3'h7;
  localparam logic [3:0]  VDL_FID_NONE = 4'h0;
  localparam logic [15:0] VDL_GC2_RST  = 16'h0000;

  // =====================================================================
  // dynamic entry: bit 71 is the not-ready flag, held in word one bit 7
  localparam int VDL_DW1_NR = 7;

  typedef enum logic [1:0] {
    VDL_IDLE = 2'b00,
    VDL_SRCH = 2'b01,
    VDL_ADDR = 2'b10
  } vdl_state_t;

endpackage : vdl_pkg

// >>> rtl/vdl_vlan_mem.sv
// sixteen-entry vlan table with one write port, one indexed read
// and one identifier search; both read results come out of registers
`timescale 1ns/1ns
module vdl_vlan_mem (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [19:0] wr_data_i,
  input  wire logic [3:0]  rd_idx_i,
  output logic      [19:0] rd_data_o,
  input  wire logic [11:0] srch_vid_i,
  output logic             srch_hit_o,
  output logic      [19:0] srch_entry_o
);
  import vdl_pkg::*;

  logic [19:0] mem_q [VDL_ENTRIES];
  logic [VDL_ENTRIES-1:0] match;
  logic        hit_d;
  logic [19:0] entry_d;

  // =====================================================================
  // entries, each reset to its default contents
  for (genvar i = 0; i < VDL_ENTRIES; i++) begin : g_ent
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mem_q[i] <= VDL_ENTRY_RST;
      end else if (wr_en_i && wr_idx_i == 4'(i)) begin
        mem_q[i] <= wr_data_i;
      end
    end
    assign match[i] = mem_q[i][VDL_E_VIDH:0] == srch_vid_i;
  end

  // =====================================================================
  // lowest matching entry wins; validity is judged by the caller
  always_comb begin
    hit_d   = 1'b0;
    entry_d = '0;
    for (int i = VDL_ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_d   = 1'b1;
        entry_d = mem_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o    <= '0;
      srch_hit_o   <= 1'b0;
      srch_entry_o <= '0;
    end else begin
      rd_data_o    <= mem_q[rd_idx_i];
      srch_hit_o   <= hit_d;
      srch_entry_o <= entry_d;
    end
  end

endmodule : vdl_vlan_mem

// >>> rtl/vdl_lookup.sv
// vlan lookup, forwarding/learning decision and indirect table access
// address lookups themselves and the dynamic table live outside;
// one packet is in flight at a time
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module vdl_lookup (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        pkt_valid_i,
  output logic             pkt_ready_o,
  input  wire logic [1:0]  pkt_port_i,
  input  wire logic        pkt_tagged_i,
  input  wire logic [11:0] pkt_vid_i,
  output logic             lkp_req_o,
  output logic      [3:0]  lkp_fid_o,
  output logic             lkp_use_fid_o,
  input  wire logic        addr_valid_i,
  input  wire logic        da_hit_i,
  input  wire logic [2:0]  da_ports_i,
  input  wire logic        sa_hit_i,
  output logic             fwd_valid_o,
  output logic             fwd_drop_o,
  output logic      [2:0]  fwd_ports_o,
  output logic             learn_o,
  output logic      [3:0]  learn_fid_o,
  output logic             dyn_rd_req_o,
  output logic      [9:0]  dyn_rd_index_o,
  input  wire logic        dyn_rd_valid_i,
  input  wire logic [71:0] dyn_rd_data_i
);
  import vdl_pkg::*;

  // =====================================================================
  // register decode
  logic [15:0] gc2_q;
  logic [11:0] pvid_q [3];
  logic [15:0] dw2_q, dw3_q, dw4_q, dw5_q;
  logic [6:0]  dw1_q;
  logic        nr_q;
  logic        vrd_pend_q;
  logic [15:0] rd_mux;
  logic [19:0] vmem_rd;

  wire         iac_wr   = reg_wr_i && reg_addr_i == VDL_ADR_IAC;
  wire [1:0]   iac_sel  = reg_wdata_i[VDL_IAC_SELH:VDL_IAC_SELL];
  wire         iac_rd   = reg_wdata_i[VDL_IAC_RD];
  wire         vlan_wr  = iac_wr && iac_sel == VDL_SEL_VLAN && !iac_rd;
  wire         vlan_rd  = iac_wr && iac_sel == VDL_SEL_VLAN && iac_rd;
  wire         dyn_rd   = iac_wr && iac_sel == VDL_SEL_DYN && iac_rd;
  wire         dyn_ld   = nr_q && dyn_rd_valid_i;
  wire         vlan_on  = gc2_q[VDL_GC2_VLAN];
  wire [19:0]  vlan_wdata = {dw5_q[3:0], dw4_q};

  wire wr_dw2 = reg_wr_i && reg_addr_i == VDL_ADR_DW2;
  wire wr_dw3 = reg_wr_i && reg_addr_i == VDL_ADR_DW3;
  wire wr_dw4 = reg_wr_i && reg_addr_i == VDL_ADR_DW4;
  wire wr_dw5 = reg_wr_i && reg_addr_i == VDL_ADR_DW5;
  wire wr_dw1 = reg_wr_i && reg_addr_i == VDL_ADR_DW1;
  wire wr_gc2 = reg_wr_i && reg_addr_i == VDL_ADR_GC2;

  // =====================================================================
  // data words: a table load beats a software write in the same cycle
  wire [15:0] dw4_d = vrd_pend_q ? vmem_rd[15:0]
                    : dyn_ld     ? dyn_rd_data_i[15:0]
                    : wr_dw4     ? reg_wdata_i : dw4_q;
  wire [15:0] dw5_d = vrd_pend_q ? {12'h000, vmem_rd[19:16]}
                    : dyn_ld     ? dyn_rd_data_i[31:16]
                    : wr_dw5     ? reg_wdata_i : dw5_q;
  wire [15:0] dw2_d = dyn_ld ? dyn_rd_data_i[47:32]
                    : wr_dw2 ? reg_wdata_i : dw2_q;
  // count bits 65:56 span word one bits 1:0 and word three bits 15:8
  wire [15:0] dw3_d = dyn_ld ? dyn_rd_data_i[63:48]
                    : wr_dw3 ? reg_wdata_i : dw3_q;
  wire [6:0]  dw1_d = dyn_ld ? dyn_rd_data_i[70:64]
                    : wr_dw1 ? reg_wdata_i[6:0] : dw1_q;
  // a fresh request sets not-ready even if old data lands that cycle
  wire        nr_d  = dyn_rd ? 1'b1 : dyn_ld ? 1'b0 : nr_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dw1_q <= '0;
      dw2_q <= '0;
      dw3_q <= '0;
      dw4_q <= '0;
      dw5_q <= '0;
      nr_q  <= 1'b0;
    end else begin
      dw1_q <= dw1_d;
      dw2_q <= dw2_d;
      dw3_q <= dw3_d;
      dw4_q <= dw4_d;
      dw5_q <= dw5_d;
      nr_q  <= nr_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gc2_q          <= VDL_GC2_RST;
      vrd_pend_q     <= 1'b0;
      dyn_rd_req_o   <= 1'b0;
      dyn_rd_index_o <= '0;
    end else begin
      gc2_q          <= wr_gc2 ? reg_wdata_i : gc2_q;
      vrd_pend_q     <= vlan_rd;
      dyn_rd_req_o   <= dyn_rd;
      dyn_rd_index_o <= dyn_rd ? reg_wdata_i[9:0] : dyn_rd_index_o;
    end
  end

  // =====================================================================
  // per-port default vlan identifiers
  // ports 1..3 sit at consecutive word indexes, so one decode per port
  // keeps the write enables one-hot without a separate address table
  for (genvar p = 0; p < 3; p++) begin : g_pvid
    wire wr_pv = reg_wr_i && reg_addr_i == VDL_ADR_PVID + 4'(p);
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pvid_q[p] <= VDL_PVID_RST;
      end else if (wr_pv) begin
        pvid_q[p] <= reg_wdata_i[VDL_E_VIDH:0];
      end
    end
  end

  // =====================================================================
  // read path: data stand only in the cycle after the strobe
  always_comb begin
    unique case (reg_addr_i)
      VDL_ADR_DW1:       rd_mux = {8'h00, nr_q, dw1_q};
      VDL_ADR_DW2:       rd_mux = dw2_q;
      VDL_ADR_DW3:       rd_mux = dw3_q;
      VDL_ADR_DW4:       rd_mux = dw4_q;
      VDL_ADR_DW5:       rd_mux = dw5_q;
      VDL_ADR_GC2:       rd_mux = gc2_q;
      VDL_ADR_PVID:      rd_mux = {4'h0, pvid_q[0]};
      VDL_ADR_PVID+4'h1: rd_mux = {4'h0, pvid_q[1]};
      VDL_ADR_PVID+4'h2: rd_mux = {4'h0, pvid_q[2]};
      default:           rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

  // =====================================================================
  // packet path
  // the search result is registered in the table, so a packet spends one
  // cycle in the search state; ready stays low until the decision pulse
  vdl_state_t  state_q, state_d;
  logic [1:0]  ing_q;
  logic [2:0]  mem_q;
  logic [3:0]  fid_q;
  logic        s_hit;
  logic [19:0] s_ent;
  logic        lkp_req_d, fwd_valid_d, fwd_drop_d, learn_d;
  logic [2:0]  fwd_ports_d, mem_d;
  logic [3:0]  fid_d;

  wire        take    = pkt_valid_i && pkt_ready_o;
  wire        use_tag = pkt_tagged_i && pkt_vid_i != VDL_VID_NULL;
  wire [11:0] as_vid  = use_tag ? pkt_vid_i : pvid_q[pkt_port_i];
  wire [2:0]  ing_bit = 3'h1 << ing_q;
  wire        s_ok    = s_hit && s_ent[VDL_E_VALID];
  wire [2:0]  flood   = mem_q & ~ing_bit;

  vdl_vlan_mem u_mem (
    .sys_clk_i    (sys_clk_i),
    .nrst_i       (nrst_i),
    .wr_en_i      (vlan_wr),
    .wr_idx_i     (reg_wdata_i[3:0]),
    .wr_data_i    (vlan_wdata),
    .rd_idx_i     (reg_wdata_i[3:0]),
    .rd_data_o    (vmem_rd),
    .srch_vid_i   (as_vid),
    .srch_hit_o   (s_hit),
    .srch_entry_o (s_ent)
  );

  always_comb begin
    state_d     = state_q;
    lkp_req_d   = 1'b0;
    fwd_valid_d = 1'b0;
    fwd_drop_d  = 1'b0;
    learn_d     = 1'b0;
    fwd_ports_d = fwd_ports_o;
    mem_d       = mem_q;
    fid_d       = fid_q;
    unique case (state_q)
      VDL_IDLE: begin
        if (take && vlan_on) begin
          state_d = VDL_SRCH;
        end else if (take) begin
          lkp_req_d = 1'b1;
          fid_d     = VDL_FID_NONE;
          mem_d     = VDL_ALL_PORTS;
          state_d   = VDL_ADDR;
        end
      end
      VDL_SRCH: begin
        if (s_ok) begin
          lkp_req_d = 1'b1;
          fid_d     = s_ent[VDL_E_FIDH:VDL_E_FIDL];
          mem_d     = s_ent[VDL_E_MEMH:VDL_E_MEML];
          state_d   = VDL_ADDR;
        end else begin
          fwd_valid_d = 1'b1;
          fwd_drop_d  = 1'b1;
          fwd_ports_d = '0;
          state_d     = VDL_IDLE;
        end
      end
      VDL_ADDR: begin
        if (addr_valid_i) begin
          fwd_valid_d = 1'b1;
          fwd_ports_d = da_hit_i ? da_ports_i : flood;
          learn_d     = !sa_hit_i;
          state_d     = VDL_IDLE;
        end
      end
      default: state_d = VDL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= VDL_IDLE;
      ing_q   <= '0;
      mem_q   <= '0;
      fid_q   <= '0;
    end else begin
      state_q <= state_d;
      ing_q   <= take ? pkt_port_i : ing_q;
      mem_q   <= mem_d;
      fid_q   <= fid_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pkt_ready_o   <= 1'b1;
      lkp_req_o     <= 1'b0;
      lkp_fid_o     <= '0;
      lkp_use_fid_o <= 1'b0;
      fwd_valid_o   <= 1'b0;
      fwd_drop_o    <= 1'b0;
      fwd_ports_o   <= '0;
      learn_o       <= 1'b0;
      learn_fid_o   <= '0;
    end else begin
      pkt_ready_o   <= state_d == VDL_IDLE;
      lkp_req_o     <= lkp_req_d;
      lkp_fid_o     <= fid_d;
      lkp_use_fid_o <= vlan_on;
      fwd_valid_o   <= fwd_valid_d;
      fwd_drop_o    <= fwd_drop_d;
      fwd_ports_o   <= fwd_ports_d;
      learn_o       <= learn_d;
      learn_fid_o   <= fid_q;
    end
  end

endmodule : vdl_lookup

// >>> sim/vdl_checker.sv
// concurrent checks on the ports of vdl_lookup
// assumes one clock and the asynchronous active-low reset of the block
`timescale 1ns/1ns
module vdl_checker
  import vdl_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        pkt_valid_i,
  input wire logic        pkt_ready_o,
  input wire logic        lkp_req_o,
  input wire logic [3:0]  lkp_fid_o,
  input wire logic        lkp_use_fid_o,
  input wire logic        addr_valid_i,
  input wire logic        fwd_valid_o,
  input wire logic        fwd_drop_o,
  input wire logic        learn_o,
  input wire logic [3:0]  learn_fid_o,
  input wire logic        dyn_rd_req_o,
  input wire logic [9:0]  dyn_rd_index_o
);
  // ====================
  // properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read answer");
  dyn_start_a: assert property (reg_wr_i && reg_addr_i == VDL_ADR_IAC && reg_wdata_i[12:10] == 3'b110
    |=> dyn_rd_req_o && dyn_rd_index_o == 10'($past(reg_wdata_i))) else $error("dynamic read not started");
  dyn_single_a: assert property (dyn_rd_req_o |=> !dyn_rd_req_o)
    else $error("dynamic read request longer than one cycle");
  drop_no_learn_a: assert property (fwd_valid_o && fwd_drop_o |-> !learn_o)
    else $error("learning on a dropped packet");
  decide_bound_a: assert property (pkt_valid_i && pkt_ready_o |-> ##[1:2] (lkp_req_o || fwd_valid_o))
    else $error("no lookup or drop after packet taken");
  busy_after_a: assert property (pkt_valid_i && pkt_ready_o |=> !pkt_ready_o)
    else $error("ready stayed high after packet taken");
  fwd_follow_a: assert property (lkp_req_o ##1 addr_valid_i |=> fwd_valid_o && !fwd_drop_o)
    else $error("no forwarding decision after address answer");
  learn_fid_a: assert property (learn_o |-> fwd_valid_o && learn_fid_o == lkp_fid_o)
    else $error("learn without decision or with wrong filter id");
  fid_off_a: assert property (lkp_req_o && !lkp_use_fid_o |-> lkp_fid_o == 4'h0)
    else $error("filter id used with vlan mode off");

  cover property (fwd_valid_o && fwd_drop_o);
  cover property (learn_o);
  cover property (dyn_rd_req_o);
endmodule : vdl_checker

bind vdl_lookup vdl_checker u_vdl_checker (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .pkt_valid_i, .pkt_ready_o, .lkp_req_o, .lkp_fid_o, .lkp_use_fid_o,
  .addr_valid_i, .fwd_valid_o, .fwd_drop_o, .learn_o, .learn_fid_o, .dyn_rd_req_o, .dyn_rd_index_o);

// >>> sim/testbench.sv
// self-checking bench for vdl_lookup through its register port and packet path
// assumes the bench alone plays the address engine and the dynamic table
`timescale 1ns/1ns
module testbench;
  import vdl_pkg::*;
  logic        sys_clk_i = 0, nrst_i = 0;
  logic [3:0]  reg_addr_i = '0, lkp_fid_o, learn_fid_o;
  logic [15:0] reg_wdata_i = '0, reg_rdata_o, v;
  logic        reg_wr_i = 0, reg_rd_i = 0, pkt_valid_i = 0, pkt_ready_o, pkt_tagged_i = 0;
  logic [1:0]  pkt_port_i = '0;
  logic [11:0] pkt_vid_i = '0;
  logic        lkp_req_o, lkp_use_fid_o, addr_valid_i = 0, da_hit_i = 0, sa_hit_i = 0;
  logic [2:0]  da_ports_i = '0, fwd_ports_o;
  logic        fwd_valid_o, fwd_drop_o, learn_o, dyn_rd_req_o, dyn_rd_valid_i = 0;
  logic [9:0]  dyn_rd_index_o;
  logic [71:0] dyn_rd_data_i = '0;
  logic [3:0]  adr [5] = '{4'h1, 4'h3, 4'h2, 4'h5, 4'h4};
  logic [15:0] exp [5] = '{16'h0041, 16'hA5C3, 16'h1234, 16'h5678, 16'h9ABC};
  logic [11:0] bad [2] = '{12'h009, 12'h007};
  int          fail_count = 0, checked = 0, cyc = 0;

  vdl_lookup u_vdl_lookup (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pkt_valid_i, .pkt_ready_o, .pkt_port_i, .pkt_tagged_i, .pkt_vid_i, .lkp_req_o,
    .lkp_fid_o, .lkp_use_fid_o, .addr_valid_i, .da_hit_i, .da_ports_i, .sa_hit_i, .fwd_valid_o,
    .fwd_drop_o, .fwd_ports_o, .learn_o, .learn_fid_o, .dyn_rd_req_o, .dyn_rd_index_o,
    .dyn_rd_valid_i, .dyn_rd_data_i);

  always #2 sys_clk_i = ~sys_clk_i;

  // the whole run needs under a hundred cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  // ====================
  // access tasks
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    v = reg_rdata_o;
  endtask : rd

  // offers one header, then waits for the lookup request or the drop
  task automatic pkt(input logic [1:0] p, input logic t, input logic [11:0] id);
    int i;
    @(posedge sys_clk_i);
    pkt_valid_i  <= 1'b1;
    pkt_port_i   <= p;
    pkt_tagged_i <= t;
    pkt_vid_i    <= id;
    @(posedge sys_clk_i);
    pkt_valid_i  <= 1'b0;
    i = 0;
    do begin
      @(negedge sys_clk_i);
      i++;
    end while (!(lkp_req_o | fwd_valid_o) && i < 8);
  endtask : pkt

  task automatic flow(input logic [1:0] p, input logic t, input logic [11:0] id, input logic [3:0] f,
                      input logic dh, input logic [2:0] dp, input logic sh, input logic [2:0] ep);
    pkt(p, t, id);
    chk("lkp_req", lkp_req_o, 16'h0001);
    chk("lkp_fid", lkp_fid_o, f);
    @(posedge sys_clk_i);
    addr_valid_i <= 1'b1;
    da_hit_i     <= dh;
    da_ports_i   <= dp;
    sa_hit_i     <= sh;
    @(posedge sys_clk_i);
    addr_valid_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("fwd", {fwd_valid_o, fwd_drop_o, fwd_ports_o}, {2'b10, ep});
    chk("learn", {learn_o, learn_fid_o}, {!sh, f});
  endtask : flow

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ====================
  // test sequence
  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(VDL_ADR_GC2);
    chk("mode_reg", v, 16'h0000);
    rd(VDL_ADR_PVID);
    chk("port_vid", v, 16'h0001);
    rd(4'hA);
    chk("unmapped", v, 16'h0000);
    wr(VDL_ADR_IAC, 16'h1402);
    rd(VDL_ADR_DW5);
    chk("entry_hi", v, 16'h000F);
    rd(VDL_ADR_DW4);
    chk("entry_lo", v, 16'h0001);
    // entry 3: vid 5, fid 5, ports 1 and 3; entry 4: vid 9 but not valid
    wr(VDL_ADR_DW5, 16'h000D);
    wr(VDL_ADR_DW4, 16'h5005);
    wr(VDL_ADR_IAC, 16'h0403);
    wr(VDL_ADR_DW5, 16'h0007);
    wr(VDL_ADR_DW4, 16'h0009);
    wr(VDL_ADR_IAC, 16'h0404);
    wr(VDL_ADR_IAC, 16'h1403);
    rd(VDL_ADR_DW5);
    chk("wr_hi", v, 16'h000D);
    rd(VDL_ADR_DW4);
    chk("wr_lo", v, 16'h5005);
    wr(VDL_ADR_GC2, 16'h8000);
    flow(2'h0, 1'b1, 12'h005, 4'h5, 1'b0, 3'h0, 1'b0, 3'h4);
    chk("use_fid", lkp_use_fid_o, 16'h0001);
    wr(4'h8, 16'h0005);
    flow(2'h1, 1'b1, 12'h000, 4'h5, 1'b0, 3'h0, 1'b0, 3'h5);
    flow(2'h2, 1'b0, 12'h009, 4'h0, 1'b1, 3'h1, 1'b1, 3'h1);
    foreach (bad[i]) begin
      pkt(2'h0, 1'b1, bad[i]);
      chk("drop", {fwd_valid_o, fwd_drop_o, learn_o, lkp_req_o}, 16'h000C);
    end
    wr(VDL_ADR_GC2, 16'h0000);
    flow(2'h0, 1'b1, 12'h009, 4'h0, 1'b0, 3'h0, 1'b0, 3'h6);
    chk("use_fid", lkp_use_fid_o, 16'h0000);
    wr(VDL_ADR_IAC, 16'h1800);
    @(negedge sys_clk_i);
    chk("dyn_req", {dyn_rd_req_o, dyn_rd_index_o}, 16'h0400);
    rd(VDL_ADR_DW1);
    chk("not_ready", v[7], 16'h0001);
    @(posedge sys_clk_i);
    dyn_rd_valid_i <= 1'b1;
    dyn_rd_data_i  <= 72'h41_A5C3_1234_5678_9ABC;
    @(posedge sys_clk_i);
    dyn_rd_valid_i <= 1'b0;
    // count field 65:56 arrives split over the first two words read
    foreach (adr[i]) begin
      rd(adr[i]);
      chk("dyn_word", v, exp[i]);
    end
    results();
  end
endmodule : testbench
